// [wdit_top.sv]
// module: watchdog interval timer with register port
// Operation
// - expiry with reset enabled: 128-cycle reset
// - 16-bit counter doubles as interval timer
// - tick from clock via prescaler, divider
// - prescaler bits 15:8, period (p+1)*div
// - select bits 4:3, code 00 divides 16
// - enabling never loads reload into count
// - time-out reloads count from reload register
// - debug acknowledge blocks reset output
// - bit 5 enables counting, resets 1
// - bit 2 enables interrupt, resets 0
// - bit 0 enables reset, resets 1
// - control resets to 0x8021
// - reload register 16 bits, resets 0x8000
// - count register read/write, resets 0x8000
//
// Local design decision: the address-and-strobe port.
module wdit_top
#(
    parameter int RESET_CYCLES = wdit_pkg::WDIT_RESET_CYCLES
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // register port
    input  wire wdit_pkg::wdit_bus_req_t bus_req,
    output logic [31:0]                 bus_rdata,
    // core status
    input  wire logic                   debug_acknowledge,
    // outputs
    output logic                        wdt_irq,
    output logic                        wdt_reset
);
    import wdit_pkg::*;

    // ==========================================================
    // assertion clocking
    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // ==========================================================
    // registers
    logic [15:0] watchdog_control;
    logic [15:0] watchdog_reload_value;
    logic [15:0] watchdog_current_count;
    logic [7:0]  pre_cnt;
    logic [6:0]  div_cnt;
    logic [7:0]  rst_cnt;
    logic        pre_tick;
    logic        tick;
    logic        timeout;
    logic [6:0]  div_last;
    logic        wr_ctl;
    logic        wr_rel;
    logic        wr_cnt;
    logic        ctl_en;
    logic        ctl_irq;
    logic        ctl_rst;
    logic [7:0]  ctl_pre;
    wdit_div_t   ctl_sel;

    assign ctl_en  = watchdog_control[WDIT_EN_BIT];
    assign ctl_irq = watchdog_control[WDIT_IRQ_EN_BIT];
    assign ctl_rst = watchdog_control[WDIT_RST_EN_BIT];
    assign ctl_pre = watchdog_control[WDIT_PRE_MSB:WDIT_PRE_LSB];
    assign ctl_sel = wdit_div_t'(watchdog_control[WDIT_SEL_MSB:WDIT_SEL_LSB]);

    assign wr_ctl = bus_req.wr && (bus_req.addr == WDIT_ADDR_CONTROL);
    assign wr_rel = bus_req.wr && (bus_req.addr == WDIT_ADDR_RELOAD);
    assign wr_cnt = bus_req.wr && (bus_req.addr == WDIT_ADDR_COUNT);

    // ==========================================================
    // control register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            watchdog_control <= WDIT_CONTROL_RST;
        end else if (wr_ctl) begin
            watchdog_control <= bus_req.wdata[15:0] & WDIT_CONTROL_MASK;
        end
    end

    a_control_write: assert property (
        wr_ctl |=> watchdog_control
                   == ($past(bus_req.wdata[15:0]) & WDIT_CONTROL_MASK))
        else $error("control write wrong");

    a_control_hold: assert property (
        !wr_ctl |=> $stable(watchdog_control))
        else $error("control changed without write");

    // ==========================================================
    // reload register
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            watchdog_reload_value <= WDIT_RELOAD_RST;
        end else if (wr_rel) begin
            watchdog_reload_value <= bus_req.wdata[15:0];
        end
    end

    a_reload_write: assert property (
        wr_rel |=> watchdog_reload_value == $past(bus_req.wdata[15:0]))
        else $error("reload write wrong");

    a_reload_hold: assert property (
        !wr_rel |=> $stable(watchdog_reload_value))
        else $error("reload changed without write");

    // ==========================================================
    // prescaler
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pre_cnt <= 8'h00;
        end else if (!ctl_en) begin
            pre_cnt <= 8'h00;
        end else if (pre_cnt >= ctl_pre) begin
            pre_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
    end
    assign pre_tick = ctl_en && (pre_cnt >= ctl_pre);

    a_pre_clear: assert property (
        !ctl_en |=> pre_cnt == 8'h00)
        else $error("prescaler not cleared");

    a_pre_step: assert property (
        ctl_en && !pre_tick |=> pre_cnt == $past(pre_cnt) + 8'h01)
        else $error("prescaler step wrong");

    // ==========================================================
    // divider
    always_comb begin
        unique case (ctl_sel)
            WDIT_DIV16:  div_last = 7'h0f;
            WDIT_DIV32:  div_last = 7'h1f;
            WDIT_DIV64:  div_last = 7'h3f;
            WDIT_DIV128: div_last = 7'h7f;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 7'h00;
        end else if (!ctl_en) begin
            div_cnt <= 7'h00;
        end else if (pre_tick) begin
            div_cnt <= (div_cnt >= div_last) ? 7'h00 : div_cnt + 7'h01;
        end
    end
    assign tick = pre_tick && (div_cnt >= div_last);

    a_div_wrap: assert property (
        tick |=> div_cnt == 7'h00)
        else $error("divider not wrapped");

    a_div_hold: assert property (
        ctl_en && !pre_tick |=> $stable(div_cnt))
        else $error("divider moved between prescaler ticks");

    a_tick_div16: assert property (
        tick && ctl_pre == 8'h00 && ctl_sel == WDIT_DIV16 && !wr_ctl
        |=> !tick [*8])
        else $error("tick spacing short");

    // ==========================================================
    // down-counter
    // time-out when count at zero on tick
    assign timeout = tick && (watchdog_current_count == 16'h0000);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            watchdog_current_count <= WDIT_COUNT_RST;
        end else if (wr_cnt) begin
            watchdog_current_count <= bus_req.wdata[15:0];
        end else if (timeout) begin
            watchdog_current_count <= watchdog_reload_value;
        end else if (tick) begin
            watchdog_current_count <= watchdog_current_count - 16'h0001;
        end
    end

    a_count_write: assert property (
        wr_cnt |=> watchdog_current_count == $past(bus_req.wdata[15:0]))
        else $error("count write wrong");

    a_count_reload: assert property (
        timeout && !wr_cnt |=> watchdog_current_count
                               == $past(watchdog_reload_value))
        else $error("no reload after time-out");

    a_count_dec: assert property (
        tick && !timeout && !wr_cnt |=> watchdog_current_count
                         == $past(watchdog_current_count) - 16'h0001)
        else $error("count not decremented");

    a_stop_hold: assert property (
        !ctl_en && !wr_cnt |=> $stable(watchdog_current_count))
        else $error("count moved while stopped");

    // ==========================================================
    // interrupt pulse
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wdt_irq <= 1'b0;
        end else begin
            wdt_irq <= timeout && ctl_irq;
        end
    end

    a_irq_cause: assert property (
        wdt_irq |-> $past(timeout) && $past(ctl_irq))
        else $error("interrupt without cause");

    a_irq_raise: assert property (
        timeout && ctl_irq |=> wdt_irq)
        else $error("interrupt missed");

    a_irq_pulse: assert property (
        wdt_irq |=> !wdt_irq)
        else $error("interrupt longer than one cycle");

    a_irq_off: assert property (
        !ctl_irq |=> !wdt_irq)
        else $error("interrupt while disabled");

    // ==========================================================
    // reset pulse
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rst_cnt   <= 8'h00;
            wdt_reset <= 1'b0;
        end else if (timeout && ctl_rst && !debug_acknowledge
                     && !wdt_reset) begin
            rst_cnt   <= 8'(RESET_CYCLES - 1);
            wdt_reset <= 1'b1;
        end else if (wdt_reset) begin
            if (rst_cnt == 8'h00) begin
                wdt_reset <= 1'b0;
            end else begin
                rst_cnt <= rst_cnt - 8'h01;
            end
        end
    end

    // pulse length counter
    logic [8:0] rst_len;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rst_len <= 9'h000;
        end else begin
            rst_len <= wdt_reset ? rst_len + 9'h001 : 9'h000;
        end
    end

    a_reset_len_max: assert property (
        rst_len <= 9'(RESET_CYCLES))
        else $error("reset pulse too long");

    a_reset_len_exact: assert property (
        $fell(wdt_reset) |-> rst_len == 9'(RESET_CYCLES))
        else $error("reset pulse length wrong");

    a_reset_start: assert property (
        $rose(wdt_reset) |-> $past(timeout) && $past(ctl_rst))
        else $error("reset without enabled time-out");

    a_debug_block: assert property (
        $rose(wdt_reset) |-> !$past(debug_acknowledge))
        else $error("reset during debug");

    a_reset_load: assert property (
        $rose(wdt_reset) |-> rst_cnt == 8'(RESET_CYCLES - 1))
        else $error("reset counter not loaded");

    // ==========================================================
    // read data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                WDIT_ADDR_CONTROL: bus_rdata <= {16'h0000, watchdog_control};
                WDIT_ADDR_RELOAD:
                    bus_rdata <= {16'h0000, watchdog_reload_value};
                WDIT_ADDR_COUNT:
                    bus_rdata <= {16'h0000, watchdog_current_count};
                default:           bus_rdata <= 32'h0000_0000;
            endcase
        end else begin
            bus_rdata <= 32'h0000_0000;
        end
    end

    // ==========================================================
    // read-back checks and coverage

    a_read_control: assert property (
        bus_req.rd && bus_req.addr == WDIT_ADDR_CONTROL
        |=> bus_rdata == {16'h0000, $past(watchdog_control)})
        else $error("control read wrong");

    a_read_reload: assert property (
        bus_req.rd && bus_req.addr == WDIT_ADDR_RELOAD
        |=> bus_rdata == {16'h0000, $past(watchdog_reload_value)})
        else $error("reload read wrong");

    a_read_count: assert property (
        bus_req.rd && bus_req.addr == WDIT_ADDR_COUNT
        |=> bus_rdata == {16'h0000, $past(watchdog_current_count)})
        else $error("count read wrong");

    c_timeout: cover property (@(posedge ref_clk) timeout);
    c_div128_tick: cover property (@(posedge ref_clk)
        tick && ctl_sel == WDIT_DIV128);
    c_reset_done: cover property (@(posedge ref_clk) $fell(wdt_reset));
    c_irq: cover property (@(posedge ref_clk) wdt_irq);
    c_debug_hold: cover property (@(posedge ref_clk)
        timeout && ctl_rst && debug_acknowledge);

endmodule // wdit_top

// [wdit_pkg.sv]
// package: watchdog interval timer constants and types
package wdit_pkg;

    // ==========================================================
    // register map
    localparam logic [31:0] WDIT_ADDR_CONTROL = 32'h01d3_0000;
    localparam logic [31:0] WDIT_ADDR_RELOAD  = 32'h01d3_0004;
    localparam logic [31:0] WDIT_ADDR_COUNT   = 32'h01d3_0008;

    // ==========================================================
    // reset values
    localparam logic [15:0] WDIT_CONTROL_RST = 16'h8021;
    localparam logic [15:0] WDIT_RELOAD_RST  = 16'h8000;
    localparam logic [15:0] WDIT_COUNT_RST   = 16'h8000;

    // ==========================================================
    // control field positions
    localparam int WDIT_PRE_MSB    = 15;
    localparam int WDIT_PRE_LSB    = 8;
    localparam int WDIT_EN_BIT     = 5;
    localparam int WDIT_SEL_MSB    = 4;
    localparam int WDIT_SEL_LSB    = 3;
    localparam int WDIT_IRQ_EN_BIT = 2;
    localparam int WDIT_RST_EN_BIT = 0;
    // writable bits: reserved 7:6 and 1 read as zero
    localparam logic [15:0] WDIT_CONTROL_MASK = 16'hff3d;

    // ==========================================================
    // timing
    localparam int WDIT_RESET_CYCLES = 128;

    // ==========================================================
    // divider selection codes
    typedef enum logic [1:0] {
        WDIT_DIV16  = 2'b00,
        WDIT_DIV32  = 2'b01,
        WDIT_DIV64  = 2'b10,
        WDIT_DIV128 = 2'b11
    } wdit_div_t;

    // register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } wdit_bus_req_t;

endpackage : wdit_pkg

// [wdit_top_test.sv]
// testbench: register, divider, reset pulse and debug checks
module wdit_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import wdit_pkg::*;

    // ==========================================================
    // signals
    logic           ref_clk;
    logic           reset;
    wdit_bus_req_t  bus_req;
    logic [31:0]    bus_rdata;
    logic           debug_acknowledge;
    logic           wdt_irq;
    logic           wdt_reset;
    int             fail_count = 0;
    int             tests_run = 0;
    int             rst_len = 0;
    int             irq_cnt = 0;
    logic           rd_pend = 1'b0;
    logic [31:0]    rq[$];
    logic [31:0]    pq[$];
    logic [15:0]    rnd = 16'h000e;

    wdit_top i_wdit_top (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .bus_req           (bus_req),
        .bus_rdata         (bus_rdata),
        .debug_acknowledge (debug_acknowledge),
        .wdt_irq           (wdt_irq),
        .wdt_reset         (wdt_reset)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("tests run %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [15:0] d);
        bus_req <= '{addr: a, wdata: {16'h0000, d}, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic bus_rd(input logic [31:0] a, input logic [15:0] e);
        rq.push_back({16'h0000, e});
        bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wdt_irq !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            fail_count++;
            summarize();
        end
    endtask

    // ==========================================================
    // output watcher
    always @(posedge ref_clk) begin
        if (rd_pend) check(bus_rdata, rq.pop_front());
        rd_pend = bus_req.rd;
        if (wdt_irq === 1'b1) irq_cnt++;
        if (wdt_reset === 1'b1) rst_len++;
        else if (rst_len != 0) begin
            check(32'(rst_len), pq.size() ? pq.pop_front() : 32'h0);
            rst_len = 0;
        end
    end

    initial begin
        #2000000;
        fail_count++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial begin : main
        int n;
        int p;
        int k;
        reset = 1'b1;
        bus_req = '0;
        debug_acknowledge = 1'b0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        bus_rd(WDIT_ADDR_CONTROL, 16'h8021);
        bus_rd(WDIT_ADDR_RELOAD, 16'h8000);
        bus_rd(WDIT_ADDR_COUNT, 16'h8000);
        bus_rd(32'h01d3_000c, 16'h0000);
        bus_wr(WDIT_ADDR_CONTROL, 16'h5a3d);
        bus_rd(WDIT_ADDR_CONTROL, 16'h5a3d);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            bus_wr(WDIT_ADDR_RELOAD, rnd);
            bus_rd(WDIT_ADDR_RELOAD, rnd);
        end
        bus_wr(32'h01d3_000c, 16'h5555);
        bus_rd(WDIT_ADDR_RELOAD, rnd);
        // divider codes with random prescaler, interval mode
        for (int s = 0; s < 4; s++) begin
            rnd = lfsr(rnd);
            p = int'(rnd[1:0]);
            bus_wr(WDIT_ADDR_CONTROL, 16'h0000);
            bus_wr(WDIT_ADDR_COUNT, 16'h0002);
            bus_wr(WDIT_ADDR_RELOAD, 16'h0001);
            bus_wr(WDIT_ADDR_CONTROL, {8'(p), 3'b001, 2'(s), 3'b100});
            wait_irq(n);
            wait_irq(n);
            check(32'(n), 32'(2 * (p + 1) * (16 << s)));
            bus_rd(WDIT_ADDR_COUNT, 16'h0001);
        end
        // reset pulse from a written zero count, interrupt off
        bus_wr(WDIT_ADDR_CONTROL, 16'h0000);
        bus_wr(WDIT_ADDR_COUNT, 16'h0000);
        bus_wr(WDIT_ADDR_RELOAD, 16'hffff);
        pq.push_back(32'd128);
        k = irq_cnt;
        bus_wr(WDIT_ADDR_CONTROL, 16'h0021);
        repeat (200) @(posedge ref_clk);
        check(32'(irq_cnt), 32'(k));
        check(32'(pq.size()), 32'h0);
        // disabled count holds
        bus_wr(WDIT_ADDR_CONTROL, 16'h0000);
        bus_wr(WDIT_ADDR_COUNT, 16'h1234);
        repeat (40) @(posedge ref_clk);
        bus_rd(WDIT_ADDR_COUNT, 16'h1234);
        // debug acknowledge blocks the reset output
        debug_acknowledge <= 1'b1;
        bus_wr(WDIT_ADDR_COUNT, 16'h0000);
        bus_wr(WDIT_ADDR_CONTROL, 16'h0025);
        wait_irq(n);
        repeat (10) @(posedge ref_clk);
        check(32'(rst_len), 32'h0);
        bus_wr(WDIT_ADDR_CONTROL, 16'h0000);
        debug_acknowledge <= 1'b0;
        repeat (4) @(posedge ref_clk);
        summarize();
    end
endmodule // wdit_top_test
